// >>> pkg/capsel_cfg.svh
// Constants for the capture input pin select block
`ifndef CAPSEL_CFG_SVH
`define CAPSEL_CFG_SVH
`define ROUTE_SEL_ADDR 8'h6C
`define ROUTE_SEL_RESET 16'h0000
`define EXT_CHOICE_ADDR 8'h70
`define ADDR_MSB 7
`define F_CH0_LO 0
`define F_CH1_LO 2
`define F_CH2_LO 4
`define F_TRAP_LO 6
`define F_POS0_LO 8
`define F_POS1_LO 10
`define F_POS2_LO 12
`define F_RUN_LO 14
`define HTRANS_NONSEQ 2'b10
`define HRESP_OKAY 1'b0
`define INACTIVE_LEVEL 1'b0
`endif

// >>> pkg/capsel_pkg.sv
// Types for the capture input pin select block
package capsel_pkg;
   typedef logic [1:0] sel_code_type;
   typedef logic [15:0] route_word_type;
endpackage

// >>> rtl/capture_input_pin_select.sv
// Capture input routing register and its input multiplexers
`timescale 1ns/1ns
`include "capsel_cfg.svh"
module capture_input_pin_select
   import capsel_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RESET,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Alternative pins
   input wire logic [2:0] CAPTURE_CHANNEL_0_PINS,
   input wire logic [1:0] CAPTURE_CHANNEL_1_PINS,
   input wire logic [2:0] CAPTURE_CHANNEL_2_PINS,
   input wire logic [1:0] TRAP_INPUT_PINS,
   input wire logic [3:0] POSITION_INPUT_0_PINS,
   input wire logic [2:0] POSITION_INPUT_1_PINS,
   input wire logic [3:0] POSITION_INPUT_2_PINS,
   input wire logic [7:0] TIMER_A_HW_RUN_SOURCES,
   // Routed inputs toward the timer unit
   output logic CAPTURE_CHANNEL_0,
   output logic CAPTURE_CHANNEL_1,
   output logic CAPTURE_CHANNEL_2,
   output logic TRAP_INPUT,
   output logic POSITION_INPUT_0,
   output logic POSITION_INPUT_1,
   output logic POSITION_INPUT_2,
   output logic TIMER_A_HW_RUN_INPUT
);

   // ------------------------------------------------------------
   // Bus address phase capture
   // ------------------------------------------------------------
   logic wr_pend_r;
   logic wr_pend_nxt;
   logic [`ADDR_MSB:0] addr_r;
   logic [`ADDR_MSB:0] addr_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   route_word_type route_r;
   route_word_type route_nxt;
   logic ext_choice_r;
   logic ext_choice_nxt;
   logic take;

   assign take = HSEL && HREADY && (HTRANS == `HTRANS_NONSEQ);

   always_comb begin
      wr_pend_nxt = take && HWRITE;
      addr_nxt = take ? HADDR[`ADDR_MSB:0] : addr_r;
      rdata_nxt = rdata_r;
      if (take && !HWRITE) begin
         case (HADDR[`ADDR_MSB:0])
            `ROUTE_SEL_ADDR: begin
               rdata_nxt = {16'h0000, route_r};
            end
            `EXT_CHOICE_ADDR: begin
               rdata_nxt = {31'h0000_0000, ext_choice_r};
            end
            default: begin
               rdata_nxt = 32'h0000_0000;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   // No hardware source updates these fields; a software write is the only
   // writer, so it always wins
   always_comb begin
      route_nxt = route_r;
      ext_choice_nxt = ext_choice_r;
      if (wr_pend_r && addr_r == `ROUTE_SEL_ADDR) begin
         route_nxt = HWDATA[15:0];
      end
      if (wr_pend_r && addr_r == `EXT_CHOICE_ADDR) begin
         ext_choice_nxt = HWDATA[0];
      end
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         wr_pend_r <= 1'b0;
         addr_r <= 8'h00;
         rdata_r <= 32'h0000_0000;
         route_r <= `ROUTE_SEL_RESET;
         ext_choice_r <= 1'b0;
      end else begin
         wr_pend_r <= wr_pend_nxt;
         addr_r <= addr_nxt;
         rdata_r <= rdata_nxt;
         route_r <= route_nxt;
         ext_choice_r <= ext_choice_nxt;
      end
   end

   // Zero wait states, always OKAY
   assign HREADYOUT = 1'b1;
   assign HRESP = `HRESP_OKAY;
   assign HRDATA = rdata_r;

   // ------------------------------------------------------------
   // Input multiplexers
   // ------------------------------------------------------------
   // Only timer inputs are routed here; output pin choice lives in the
   // port logic
   sel_code_type sel_ch0;
   sel_code_type sel_ch1;
   sel_code_type sel_ch2;
   sel_code_type sel_trap;
   sel_code_type sel_pos0;
   sel_code_type sel_pos1;
   sel_code_type sel_pos2;
   sel_code_type sel_run;

   assign sel_ch0 = route_r[`F_CH0_LO +: 2];
   assign sel_ch1 = route_r[`F_CH1_LO +: 2];
   assign sel_ch2 = route_r[`F_CH2_LO +: 2];
   assign sel_trap = route_r[`F_TRAP_LO +: 2];
   assign sel_pos0 = route_r[`F_POS0_LO +: 2];
   assign sel_pos1 = route_r[`F_POS1_LO +: 2];
   assign sel_pos2 = route_r[`F_POS2_LO +: 2];
   assign sel_run = route_r[`F_RUN_LO +: 2];

   // ------------------------------------------------------------
   // Channel 0 capture input; reserved code reads inactive
   // ------------------------------------------------------------
   always_comb begin
      case (sel_ch0)
         2'h0: begin
            CAPTURE_CHANNEL_0 = CAPTURE_CHANNEL_0_PINS[0];
         end
         2'h1: begin
            CAPTURE_CHANNEL_0 = CAPTURE_CHANNEL_0_PINS[1];
         end
         2'h2: begin
            CAPTURE_CHANNEL_0 = CAPTURE_CHANNEL_0_PINS[2];
         end
         default: CAPTURE_CHANNEL_0 = `INACTIVE_LEVEL;
      endcase
   end

   // ------------------------------------------------------------
   // Channel 1 capture input; two reserved codes
   // ------------------------------------------------------------
   always_comb begin
      case (sel_ch1)
         2'h0: begin
            CAPTURE_CHANNEL_1 = CAPTURE_CHANNEL_1_PINS[0];
         end
         2'h1: begin
            CAPTURE_CHANNEL_1 = CAPTURE_CHANNEL_1_PINS[1];
         end
         default: CAPTURE_CHANNEL_1 = `INACTIVE_LEVEL;
      endcase
   end

   // ------------------------------------------------------------
   // Channel 2 capture input; reserved code reads inactive
   // ------------------------------------------------------------
   always_comb begin
      case (sel_ch2)
         2'h0: begin
            CAPTURE_CHANNEL_2 = CAPTURE_CHANNEL_2_PINS[0];
         end
         2'h1: begin
            CAPTURE_CHANNEL_2 = CAPTURE_CHANNEL_2_PINS[1];
         end
         2'h2: begin
            CAPTURE_CHANNEL_2 = CAPTURE_CHANNEL_2_PINS[2];
         end
         default: CAPTURE_CHANNEL_2 = `INACTIVE_LEVEL;
      endcase
   end

   // ------------------------------------------------------------
   // Trap input; a stray pin here could halt the outputs
   // ------------------------------------------------------------
   always_comb begin
      case (sel_trap)
         2'h0: begin
            TRAP_INPUT = TRAP_INPUT_PINS[0];
         end
         2'h1: begin
            TRAP_INPUT = TRAP_INPUT_PINS[1];
         end
         default: TRAP_INPUT = `INACTIVE_LEVEL;
      endcase
   end

   // ------------------------------------------------------------
   // Position input 0; all four codes are pins
   // ------------------------------------------------------------
   always_comb begin
      case (sel_pos0)
         2'h0: begin
            POSITION_INPUT_0 = POSITION_INPUT_0_PINS[0];
         end
         2'h1: begin
            POSITION_INPUT_0 = POSITION_INPUT_0_PINS[1];
         end
         2'h2: begin
            POSITION_INPUT_0 = POSITION_INPUT_0_PINS[2];
         end
         2'h3: begin
            POSITION_INPUT_0 = POSITION_INPUT_0_PINS[3];
         end
         default: POSITION_INPUT_0 = `INACTIVE_LEVEL;
      endcase
   end

   // ------------------------------------------------------------
   // Position input 1; reserved code reads inactive
   // ------------------------------------------------------------
   always_comb begin
      case (sel_pos1)
         2'h0: begin
            POSITION_INPUT_1 = POSITION_INPUT_1_PINS[0];
         end
         2'h1: begin
            POSITION_INPUT_1 = POSITION_INPUT_1_PINS[1];
         end
         2'h2: begin
            POSITION_INPUT_1 = POSITION_INPUT_1_PINS[2];
         end
         default: POSITION_INPUT_1 = `INACTIVE_LEVEL;
      endcase
   end

   // ------------------------------------------------------------
   // Position input 2; all four codes are pins
   // ------------------------------------------------------------
   always_comb begin
      case (sel_pos2)
         2'h0: begin
            POSITION_INPUT_2 = POSITION_INPUT_2_PINS[0];
         end
         2'h1: begin
            POSITION_INPUT_2 = POSITION_INPUT_2_PINS[1];
         end
         2'h2: begin
            POSITION_INPUT_2 = POSITION_INPUT_2_PINS[2];
         end
         2'h3: begin
            POSITION_INPUT_2 = POSITION_INPUT_2_PINS[3];
         end
         default: POSITION_INPUT_2 = `INACTIVE_LEVEL;
      endcase
   end

   // ------------------------------------------------------------
   // Hardware run input; choice bit selects the upper four sources
   // ------------------------------------------------------------
   always_comb begin
      case ({ext_choice_r, sel_run})
         3'h0: begin
            TIMER_A_HW_RUN_INPUT = TIMER_A_HW_RUN_SOURCES[0];
         end
         3'h1: begin
            TIMER_A_HW_RUN_INPUT = TIMER_A_HW_RUN_SOURCES[1];
         end
         3'h2: begin
            TIMER_A_HW_RUN_INPUT = TIMER_A_HW_RUN_SOURCES[2];
         end
         3'h3: begin
            TIMER_A_HW_RUN_INPUT = TIMER_A_HW_RUN_SOURCES[3];
         end
         3'h4: begin
            TIMER_A_HW_RUN_INPUT = TIMER_A_HW_RUN_SOURCES[4];
         end
         3'h5: begin
            TIMER_A_HW_RUN_INPUT = TIMER_A_HW_RUN_SOURCES[5];
         end
         3'h6: begin
            TIMER_A_HW_RUN_INPUT = TIMER_A_HW_RUN_SOURCES[6];
         end
         3'h7: begin
            TIMER_A_HW_RUN_INPUT = TIMER_A_HW_RUN_SOURCES[7];
         end
         default: TIMER_A_HW_RUN_INPUT = `INACTIVE_LEVEL;
      endcase
   end

endmodule

// >>> dv/port_pins.sv
// Partner model: port pins and run sources feeding the select block
`timescale 1ns/1ns
module port_pins (
   input wire logic CLOCK,
   input wire logic [28:0] lv,
   output logic [2:0] CAPTURE_CHANNEL_0_PINS, CAPTURE_CHANNEL_2_PINS, POSITION_INPUT_1_PINS,
   output logic [1:0] CAPTURE_CHANNEL_1_PINS, TRAP_INPUT_PINS,
   output logic [3:0] POSITION_INPUT_0_PINS, POSITION_INPUT_2_PINS,
   output logic [7:0] TIMER_A_HW_RUN_SOURCES
);
   // Pins move only at edges, like synchronised port levels
   always_ff @(posedge CLOCK) begin
      {TIMER_A_HW_RUN_SOURCES, POSITION_INPUT_2_PINS, POSITION_INPUT_1_PINS,
       POSITION_INPUT_0_PINS, TRAP_INPUT_PINS, CAPTURE_CHANNEL_2_PINS,
       CAPTURE_CHANNEL_1_PINS, CAPTURE_CHANNEL_0_PINS} <= lv;
   end
endmodule

// >>> dv/capsel_props.sv
// Checker: routed inputs against a shadow of the select register
`timescale 1ns/1ns
`include "capsel_cfg.svh"
module capsel_props (
   input wire logic CLOCK, RESET, HSEL, HWRITE, HREADY, HREADYOUT, HRESP,
   input wire logic [1:0] HTRANS,
   input wire logic [31:0] HADDR, HWDATA,
   input wire logic [2:0] CAPTURE_CHANNEL_0_PINS, CAPTURE_CHANNEL_2_PINS, POSITION_INPUT_1_PINS,
   input wire logic [1:0] CAPTURE_CHANNEL_1_PINS, TRAP_INPUT_PINS,
   input wire logic [3:0] POSITION_INPUT_0_PINS, POSITION_INPUT_2_PINS,
   input wire logic [7:0] TIMER_A_HW_RUN_SOURCES,
   input wire logic CAPTURE_CHANNEL_0, CAPTURE_CHANNEL_1, CAPTURE_CHANNEL_2, TRAP_INPUT,
   input wire logic POSITION_INPUT_0, POSITION_INPUT_1, POSITION_INPUT_2, TIMER_A_HW_RUN_INPUT
);
   logic [15:0] s;
   logic x, pw, px, go;
   assign go = HSEL && HREADY && HTRANS == `HTRANS_NONSEQ && HWRITE;
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         {s, x, pw, px} <= '0;
      end else begin
         if (pw) s <= HWDATA[15:0];
         if (px) x <= HWDATA[0];
         pw <= go && HADDR[7:0] == `ROUTE_SEL_ADDR;
         px <= go && HADDR[7:0] == `EXT_CHOICE_ADDR;
      end
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RESET);
   a_ch0_route: assert property (CAPTURE_CHANNEL_0 == (s[1:0] < 3 &&
      CAPTURE_CHANNEL_0_PINS[s[1:0]])) else $error("channel 0 route wrong");
   a_ch1_route: assert property (CAPTURE_CHANNEL_1 == (s[3:2] < 2 &&
      CAPTURE_CHANNEL_1_PINS[s[2]])) else $error("channel 1 route wrong");
   a_ch2_route: assert property (CAPTURE_CHANNEL_2 == (s[5:4] < 3 &&
      CAPTURE_CHANNEL_2_PINS[s[5:4]])) else $error("channel 2 route wrong");
   a_trap_route: assert property (TRAP_INPUT == (s[7:6] < 2 &&
      TRAP_INPUT_PINS[s[6]])) else $error("trap route wrong");
   a_pos0_route: assert property (POSITION_INPUT_0 ==
      POSITION_INPUT_0_PINS[s[9:8]]) else $error("position 0 route wrong");
   a_pos1_route: assert property (POSITION_INPUT_1 == (s[11:10] < 3 &&
      POSITION_INPUT_1_PINS[s[11:10]])) else $error("position 1 route wrong");
   a_pos2_route: assert property (POSITION_INPUT_2 ==
      POSITION_INPUT_2_PINS[s[13:12]]) else $error("position 2 route wrong");
   a_run_route: assert property (TIMER_A_HW_RUN_INPUT ==
      TIMER_A_HW_RUN_SOURCES[{x, s[15:14]}]) else $error("run input route wrong");
   a_bus_okay: assert property (HREADYOUT && HRESP == `HRESP_OKAY) else $error("bus stall");
endmodule
bind capture_input_pin_select capsel_props chk_u (.*);

// >>> dv/tb_top.sv
// Testbench: select register traffic and routed input checks
`timescale 1ns/1ns
module tb_top;
   logic CLOCK = 0, RESET = 1, HSEL = 1, HWRITE = 0, HREADY, HREADYOUT, HRESP, x;
   logic [1:0] HTRANS = 0;
   logic [2:0] HSIZE = 3'b010;
   logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, q, rs = 32'ha68d;
   logic [2:0] CAPTURE_CHANNEL_0_PINS, CAPTURE_CHANNEL_2_PINS, POSITION_INPUT_1_PINS;
   logic [1:0] CAPTURE_CHANNEL_1_PINS, TRAP_INPUT_PINS;
   logic [3:0] POSITION_INPUT_0_PINS, POSITION_INPUT_2_PINS;
   logic [7:0] TIMER_A_HW_RUN_SOURCES;
   logic CAPTURE_CHANNEL_0, CAPTURE_CHANNEL_1, CAPTURE_CHANNEL_2, TRAP_INPUT;
   logic POSITION_INPUT_0, POSITION_INPUT_1, POSITION_INPUT_2, TIMER_A_HW_RUN_INPUT;
   logic [28:0] lv = 0;
   logic [15:0] w;
   int bad_count = 0, n_compared = 0, cyc = 0;
   assign HREADY = HREADYOUT;
   capture_input_pin_select dut_u (.*);
   port_pins pp_u (.*);
   always #20 CLOCK = ~CLOCK;
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   // Reserved codes must read as a low level, never a stray pin
   function automatic logic [7:0] ex(input logic [15:0] s, input logic e, input logic [28:0] p);
      return {p[21 + {e, s[15:14]}], p[17 + s[13:12]], s[11:10] < 3 && p[14 + s[11:10]],
         p[10 + s[9:8]], s[7:6] < 2 && p[8 + s[6]], s[5:4] < 3 && p[5 + s[5:4]],
         s[3:2] < 2 && p[3 + s[2]], s[1:0] < 3 && p[s[1:0]]};
   endfunction
   task automatic end_sim;
      if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      HADDR <= a;
      HWRITE <= wr;
      HTRANS <= 2'b10;
      do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'b00;
      HWDATA <= d;
      do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
      q = HRDATA;
   endtask
   always @(posedge CLOCK) if (++cyc == 5000) begin
      bad_count++;
      end_sim;
   end
   initial begin
      repeat (4) @(posedge CLOCK);
      RESET <= 0;
      bus(0, 32'h0000_006c, 0);
      chk("reset value", q, 0);
      // Every code in every field under both run choices, then random words
      for (int i = 0; i < 40; i++) begin
         rs = xs(rs);
         w = i < 8 ? {8{i[1:0]}} : rs[15:0];
         x = i < 8 ? i[2] : rs[16];
         lv <= xs(rs);
         bus(1, 32'h0000_006c, {rs[31:16], w});
         bus(1, 32'h0000_0070, {31'h0, x});
         #1 chk("routed", {TIMER_A_HW_RUN_INPUT, POSITION_INPUT_2, POSITION_INPUT_1,
            POSITION_INPUT_0, TRAP_INPUT, CAPTURE_CHANNEL_2, CAPTURE_CHANNEL_1,
            CAPTURE_CHANNEL_0}, ex(w, x, lv));
         bus(0, 32'h0000_006c, 0);
         chk("select word", q, {16'h0000, w});
         bus(0, 32'h0000_0070, 0);
         chk("run choice", q, {31'h0, x});
      end
      bus(0, 32'h0000_0010, 0);
      chk("unmapped", q, 0);
      end_sim;
   end
endmodule
